// file: ppcs_pkg.sv
// ppcs_pkg: register layout, reset values and carrier types for the chip select config block
// assumes: a plain register port with one 16-bit register, one system clock
package ppcs_pkg;
    localparam int          PPCS_ADDR_W      = 4;
    localparam logic [3:0]  PPCS_CFG_OFFSET  = 4'h0;    // config register offset
    localparam logic [15:0] PPCS_CFG_RESET   = 16'h0000; // value after power-on reset
    localparam logic [15:0] PPCS_CFG_IMPL    = 16'hF7E0; // implemented bit mask
    localparam int          PPCS_SELDIS_BIT  = 15;
    localparam int          PPCS_SELPOL_BIT  = 14;
    localparam int          PPCS_SELPEN_BIT  = 13;
    localparam int          PPCS_LANEPOL_BIT = 12;
    localparam int          PPCS_WRPOL_BIT   = 10;
    localparam int          PPCS_RDPOL_BIT   = 9;
    localparam int          PPCS_STYLE_BIT   = 8;
    localparam int          PPCS_ACKPOL_BIT  = 7;
    localparam int          PPCS_WIDTH_LSB   = 5;
    localparam logic [1:0]  PPCS_WIDTH_8     = 2'h0;    // 8-bit data port
    localparam logic [1:0]  PPCS_WIDTH_4     = 2'h1;    // 4-bit data port

    // register port request
    typedef struct packed {
        logic [PPCS_ADDR_W-1:0] addr;   // register address
        logic [15:0]            wdata;  // write data
        logic                   wr;     // write strobe
        logic                   rd;     // read strobe
    } ppcs_req_t;

    // access request from the port timing engine
    typedef struct packed {
        logic active;   // access in progress
        logic isWrite;  // access is a write
        logic strobe;   // strobe phase asserted
        logic lane0;    // lane 0 enabled
        logic lane1;    // lane 1 enabled
    } ppcs_acc_t;

    // pin levels toward the external bus
    typedef struct packed {
        logic readStrobePin;     // read strobe, or direction line in the combined style
        logic writeStrobePin;    // write strobe
        logic enableStrobePin;   // enable strobe
        logic chipSelectOutput;  // chip select level
        logic selectPinOeN;      // select pin enable, low drives
        logic laneEnable0;       // lane enable 0 level
        logic laneEnable1;       // lane enable 1 level
    } ppcs_pins_t;
endpackage

// file: ppcs_cfg.sv
// ppcs_cfg: chip select region configuration register and pin polarity/strobe style logic
// assumes: synchronous inputs, a timing engine supplying access phases, 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module ppcs_cfg
    import ppcs_pkg::*;
(
    input  wire logic                clock,        // system clock
    input  wire logic                rst_n,        // async reset, active low
    input  wire ppcs_pkg::ppcs_req_t req,          // register port request
    output var  logic [15:0]         rdata,        // read data, cycle after read
    input  wire ppcs_pkg::ppcs_acc_t acc,          // access phase from timing engine
    input  wire logic                handshakeAckInput, // external acknowledge pin
    output var  ppcs_pkg::ppcs_pins_t pins,        // registered pin levels
    output var  logic                ackSeen,      // acknowledge asserted, registered
    output var  logic                nibbleMode,   // 1 when 4-bit port selected
    output var  logic                widthReserved // reserved width code in use
);
    import ppcs_pkg::*;

    // lane enable pins served by this region; the pin carrier holds two
    localparam int LANE_CNT = 2;

    // elaboration checks: the package layout must suit the decode below
    // the offset compare needs the offset as wide as the bus address
    if (PPCS_ADDR_W != $bits(PPCS_CFG_OFFSET)) begin : g_chk_addr
        $error("register offset width differs from the address width");
    end
    // the two-bit width field must lie inside the register
    if (PPCS_WIDTH_LSB < 0 || PPCS_WIDTH_LSB > 14) begin : g_chk_width
        $error("port width field lies outside the register");
    end
    // a value after reset may not set an unimplemented bit
    if ((PPCS_CFG_RESET & ~PPCS_CFG_IMPL) != 16'h0000) begin : g_chk_reset
        $error("reset value sets an unimplemented bit");
    end
    // every decoded field must sit on an implemented bit
    if (!PPCS_CFG_IMPL[PPCS_SELDIS_BIT] || !PPCS_CFG_IMPL[PPCS_SELPOL_BIT]
        || !PPCS_CFG_IMPL[PPCS_SELPEN_BIT] || !PPCS_CFG_IMPL[PPCS_LANEPOL_BIT]) begin : g_sel
        $error("a select field sits on an unimplemented bit");
    end
    if (!PPCS_CFG_IMPL[PPCS_WRPOL_BIT] || !PPCS_CFG_IMPL[PPCS_RDPOL_BIT]
        || !PPCS_CFG_IMPL[PPCS_STYLE_BIT] || !PPCS_CFG_IMPL[PPCS_ACKPOL_BIT]) begin : g_strb
        $error("a strobe field sits on an unimplemented bit");
    end
    if (!PPCS_CFG_IMPL[PPCS_WIDTH_LSB] || !PPCS_CFG_IMPL[PPCS_WIDTH_LSB + 1]) begin : g_wbits
        $error("the port width field sits on an unimplemented bit");
    end

    // register state
    logic [15:0] cfg;           // configuration register, implemented bits only
    logic [15:0] next_cfg;      // value stored on a write
    logic        hitCfg;        // address decodes to the config register
    logic        wrCfg;         // write strobe aimed at the config register
    logic        rdCfg;         // read strobe aimed at the config register
    logic [15:0] next_rdata;    // read data for the next cycle

    // configuration fields
    logic        selDis;        // select_disable: region switched off
    logic        selPol;        // select_polarity: 1 drives the select high
    logic        selPen;        // select_pin_enable: select pin owned by the port
    logic        lanePol;       // lane_enable_polarity: 1 drives the lanes high
    logic        wrPol;         // write_strobe_polarity, enable polarity in style 1
    logic        rdPol;         // read_strobe_polarity, direction polarity in style 1
    logic        style;         // strobe_style_select: 1 combined, 0 separate
    logic        ackPol;        // acknowledge_polarity: level that means acknowledge
    logic [1:0]  portWidth;     // port_width_select code

    // access qualification
    logic        csOn;          // region selected and not disabled
    logic        rdStrobeOn;    // read strobe phase for this region
    logic        wrStrobeOn;    // write strobe phase for this region
    logic        dirRead;       // direction line asserted, a read is in progress

    // candidate pin levels per strobe style
    logic        dirLevel;      // combined style: direction line level
    logic        enbLevel;      // combined style: enable strobe level
    logic        parkLevel;     // combined style: unused write pin level
    logic        sepRdLevel;    // separate style: read strobe level
    logic        sepWrLevel;    // separate style: write strobe level
    logic        rdPinLevel;    // chosen level of the read strobe pin
    logic        wrPinLevel;    // chosen level of the write strobe pin
    logic        enbPinLevel;   // chosen level of the enable strobe pin

    // select and lane pins
    logic        csLevel;       // chip select level
    logic        csOeN;         // select pin output enable, low drives
    logic [LANE_CNT-1:0] laneReq;   // lanes asked for by the timing engine
    logic [LANE_CNT-1:0] laneKeep;  // lanes that the port width allows
    logic [LANE_CNT-1:0] laneLevel; // lane enable pin levels
    ppcs_pins_t  next_pins;     // pin levels for the next cycle

    // status
    logic        next_ackSeen;  // acknowledge level seen this cycle
    logic        next_nibble;   // 4-bit port selected
    logic        next_reserved; // reserved width code selected

    // level that a pin shows: the active level when asserted, the inverse when idle
    function automatic logic pinLevel(input logic asserted, input logic activeHigh);
        return asserted ~^ activeHigh;
    endfunction

    // width code of the 4-bit port
    function automatic logic nibbleWidth(input logic [1:0] code);
        return code == PPCS_WIDTH_4;
    endfunction

    // codes other than the 8-bit and 4-bit ports are reserved
    function automatic logic reservedWidth(input logic [1:0] code);
        return (code != PPCS_WIDTH_8) && (code != PPCS_WIDTH_4);
    endfunction

    // address decoding, only the config offset is mapped
    assign hitCfg      = (req.addr == PPCS_CFG_OFFSET);
    assign wrCfg       = req.wr && hitCfg;
    assign rdCfg       = req.rd && hitCfg;
    // write value keeps only the implemented bits
    assign next_cfg    = req.wdata & PPCS_CFG_IMPL;
    // read value, zero outside the map or without a read
    assign next_rdata  = rdCfg ? (cfg & PPCS_CFG_IMPL) : 16'h0000;

    // field extraction
    assign selDis      = cfg[PPCS_SELDIS_BIT];
    assign selPol      = cfg[PPCS_SELPOL_BIT];
    assign selPen      = cfg[PPCS_SELPEN_BIT];
    assign lanePol     = cfg[PPCS_LANEPOL_BIT];
    assign wrPol       = cfg[PPCS_WRPOL_BIT];
    assign rdPol       = cfg[PPCS_RDPOL_BIT];
    assign style       = cfg[PPCS_STYLE_BIT];
    assign ackPol      = cfg[PPCS_ACKPOL_BIT];
    assign portWidth   = cfg[PPCS_WIDTH_LSB +: 2];

    // access qualification: a disabled region never selects or strobes
    assign csOn        = acc.active && !selDis;
    assign rdStrobeOn  = csOn && acc.strobe && !acc.isWrite;
    assign wrStrobeOn  = csOn && acc.strobe && acc.isWrite;
    assign dirRead     = csOn && !acc.isWrite;

    // combined style: one direction line plus an enable strobe
    assign dirLevel    = pinLevel(dirRead, rdPol);
    assign enbLevel    = pinLevel(rdStrobeOn || wrStrobeOn, wrPol);
    // the write pin has no job in the combined style, so it parks idle
    assign parkLevel   = pinLevel(1'b0, wrPol);
    // separate style: one strobe for each direction
    assign sepRdLevel  = pinLevel(rdStrobeOn, rdPol);
    assign sepWrLevel  = pinLevel(wrStrobeOn, wrPol);
    // the style bit picks which strobe pins act
    assign rdPinLevel  = style ? dirLevel : sepRdLevel;
    assign wrPinLevel  = style ? parkLevel : sepWrLevel;
    // enable strobe stays low whenever the separate strobes are in use
    assign enbPinLevel = style ? enbLevel : 1'b0;

    // chip select level and the pin enable, low while the port drives it
    assign csLevel     = pinLevel(csOn, selPol);
    assign csOeN       = !(selPen && !selDis);

    // lane enables; lane 1 has no data behind it in the 4-bit port
    assign laneReq     = {acc.lane1, acc.lane0};
    assign laneKeep    = {!nibbleWidth(portWidth), 1'b1};
    for (genvar i = 0; i < LANE_CNT; i++) begin : g_lane
        // each lane pin follows its request at the lane polarity while the port width keeps that lane
        assign laneLevel[i] = pinLevel(csOn && laneReq[i] && laneKeep[i], lanePol);
    end

    // pin levels gathered for the output register
    assign next_pins = '{
        readStrobePin:    rdPinLevel,
        writeStrobePin:   wrPinLevel,
        enableStrobePin:  enbPinLevel,
        chipSelectOutput: csLevel,
        selectPinOeN:     csOeN,
        laneEnable0:      laneLevel[0],
        laneEnable1:      laneLevel[1]
    };

    // status decode
    assign next_ackSeen  = (handshakeAckInput == ackPol);
    assign next_nibble   = nibbleWidth(portWidth);
    assign next_reserved = reservedWidth(portWidth);

    // register write, only implemented bits stored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= PPCS_CFG_RESET;
        end else if (wrCfg) begin
            cfg <= next_cfg;
        end
    end

    // read data stands for the one cycle after the read strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    // registered pin levels, one cycle behind config and access inputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pins <= '0;
        end else begin
            pins <= next_pins;
        end
    end

    // registered status flags
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ackSeen       <= 1'b0;
            nibbleMode    <= 1'b0;
            widthReserved <= 1'b0;
        end else begin
            ackSeen       <= next_ackSeen;
            nibbleMode    <= next_nibble;
            widthReserved <= next_reserved;
        end
    end
endmodule
`default_nettype wire

// file: ppcs_cfg_checker.sv
// ppcs_cfg_checker: port assertions for the config block
// assumes: bound to ppcs_cfg, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ppcs_cfg_checker
    import ppcs_pkg::*;
(
    input wire logic                 clock,             // clock
    input wire logic                 rst_n,             // reset
    input wire ppcs_pkg::ppcs_req_t  req,               // register request
    input wire logic [15:0]          rdata,             // read data
    input wire ppcs_pkg::ppcs_acc_t  acc,               // access phase
    input wire logic                 handshakeAckInput, // ack pin
    input wire ppcs_pkg::ppcs_pins_t pins,              // pin levels
    input wire logic                 ackSeen,           // ack seen
    input wire logic                 nibbleMode,        // 4-bit port
    input wire logic                 widthReserved      // reserved code
);
    import ppcs_pkg::*;
    logic [15:0] cfg; // shadow of the config register
    // shadow follows writes to offset 0
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) cfg <= 16'h0000;
        else if (req.wr && req.addr == 4'h0) cfg <= req.wdata & PPCS_CFG_IMPL;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_rd; acc.active && !cfg[15] && acc.strobe && !acc.isWrite; endsequence
    property p_rd; req.rd && req.addr == 4'h0 |=> rdata == cfg; endproperty
    property p_un; req.rd && req.addr != 4'h0 |=> rdata == 16'h0000; endproperty
    property p_ack; 1 |=> ackSeen == ($past(handshakeAckInput) == $past(cfg[7])); endproperty
    property p_nib; 1 |=> nibbleMode == ($past(cfg[6:5]) == 2'h1); endproperty
    property p_res; 1 |=> widthReserved == $past(cfg[6]); endproperty
    property p_wi; cfg[8] && !cfg[15] |=> pins.writeStrobePin == !$past(cfg[10]); endproperty
    property p_rw; cfg[8] ##0 s_rd |=> pins.readStrobePin == $past(cfg[9]); endproperty
    property p_en; cfg[8] && !cfg[15] && acc.active && acc.strobe
        |=> pins.enableStrobePin == $past(cfg[10]); endproperty
    property p_sep; !cfg[8] ##0 s_rd |=> pins.readStrobePin == $past(cfg[9])
        && pins.writeStrobePin == !$past(cfg[10]); endproperty
    property p_en0; !cfg[8] |=> pins.enableStrobePin == 1'b0; endproperty
    property p_cs; 1 |=> pins.chipSelectOutput
        == (($past(acc.active) && !$past(cfg[15])) == $past(cfg[14])); endproperty
    property p_oe; 1 |=> pins.selectPinOeN == !($past(cfg[13]) && !$past(cfg[15])); endproperty
    property p_ln0; 1 |=> pins.laneEnable0
        == (($past(acc.active) && !$past(cfg[15]) && $past(acc.lane0)) == $past(cfg[12]));
    endproperty
    property p_ln1; cfg[6:5] == 2'h1 |=> pins.laneEnable1 == !$past(cfg[12]); endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    a_un: assert property (p_un) else $error("unmapped read not zero");
    a_ack: assert property (p_ack) else $error("ack level wrong");
    a_nib: assert property (p_nib) else $error("nibble flag wrong");
    a_res: assert property (p_res) else $error("reserved flag wrong");
    a_wi: assert property (p_wi) else $error("write strobe not idle");
    a_rw: assert property (p_rw) else $error("direction strobe wrong");
    a_en: assert property (p_en) else $error("enable strobe wrong");
    a_sep: assert property (p_sep) else $error("read strobe wrong");
    a_en0: assert property (p_en0) else $error("enable strobe used in separate style");
    a_cs: assert property (p_cs) else $error("chip select level wrong");
    a_oe: assert property (p_oe) else $error("select pin enable wrong");
    a_ln0: assert property (p_ln0) else $error("lane 0 level wrong");
    a_ln1: assert property (p_ln1) else $error("lane 1 not idle in 4-bit port");
endmodule
bind ppcs_cfg ppcs_cfg_checker u_chk (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
    .acc(acc), .handshakeAckInput(handshakeAckInput), .pins(pins), .ackSeen(ackSeen),
    .nibbleMode(nibbleMode), .widthReserved(widthReserved));
`default_nettype wire

// file: ppcs_periph.sv
// ppcs_periph: external device that answers on the ack pin
// assumes: bench tells it the configured select and ack levels
`timescale 1ns/1ps
`default_nettype none
module ppcs_periph
    import ppcs_pkg::*;
(
    input  wire logic                 clock,  // clock
    input  wire ppcs_pkg::ppcs_pins_t pins,   // device pins
    input  wire logic                 selAct, // select active level
    input  wire logic                 ackAct, // ack active level
    output var  logic                 ack     // ack pin
);
    // ack asserted a cycle after being selected, inverse level otherwise
    always_ff @(posedge clock) ack <= (pins.chipSelectOutput == selAct) ? ackAct : !ackAct;
endmodule
`default_nettype wire

// file: tb.sv
// tb: drives registers and access phases, scores read data and mode flags
// assumes: design, partner and bound checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ppcs_pkg::*;
    logic clock = 0, rst_n = 0, ack, rdNow = 0; // clock, reset, ack, read pending
    ppcs_req_t   req = '0;                       // register request
    ppcs_acc_t   acc = '0;                       // access phase
    ppcs_pins_t  pins;                           // pin levels
    logic [15:0] rdata, cfgW = 16'h0000, q [$];  // read data, config, notes
    logic        ackSeen, nibbleMode, widthReserved; // flags
    int          error_cnt = 0, checks_done = 0, seed = 3;
    always #12.5 clock = ~clock;
    ppcs_cfg u_ppcs_cfg (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata), .acc(acc),
        .handshakeAckInput(ack), .pins(pins), .ackSeen(ackSeen), .nibbleMode(nibbleMode),
        .widthReserved(widthReserved));
    ppcs_periph u_ppcs_periph (.clock(clock), .pins(pins), .selAct(cfgW[14]), .ackAct(cfgW[7]),
        .ack(ack));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, seen, want);
        end
    endtask
    // one strobe cycle; reads leave a note of the expected data
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        if (w && a == 4'h0) cfgW = d & PPCS_CFG_IMPL;
        if (!w) q.push_back(a == 4'h0 ? cfgW : 16'h0000);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // read data stands one cycle after the read strobe
    always @(posedge clock) begin
        if (rdNow) check(rdata, q.pop_front());
        rdNow <= req.rd;
    end
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1;
        bus(0, 4'h0, 16'h0000);
        bus(1, 4'h0, 16'hFFFF);
        bus(0, 4'h0, 16'h0000);
        bus(0, 4'h5, 16'h0000);
        $display("register test done");
        for (int c = 0; c < 16; c++) begin
            logic [15:0] w;
            w = 16'($random(seed));
            w[6:5] = c[1:0];
            bus(1, 4'h0, w);
            bus(0, 4'h0, 16'h0000);
            @(posedge clock);
            req <= '0;
            repeat (4) @(posedge clock) acc <= 5'($random(seed));
            @(negedge clock);
            check(16'(nibbleMode), 16'(c[1:0] == 2'h1));
            check(16'(widthReserved), 16'(c[1]));
        end
        $display("mode test done");
        test_done();
    end
    initial begin
        #20us;
        error_cnt++;
        test_done();
    end
endmodule
`default_nettype wire
